/* verilog/spp_prog_port.sv */
// Notes on behaviour
// - four pins: mode select, serial command in, response out, clock.
// - 32-bit command, bit 31 first, one bit per clock pulse.
// - response to the previous command shifts out while a command enters.
// - first response after entry is undefined; programmer ignores it.
// - during a write the response pin is a ready line, driven low.
// - finished memory write sets write done, so ready goes high.
// - power loss ends programming mode; new entry needed.
// - bit 29 selects data memory, bit 28 code memory; only that one.
// - bit 24 one means read, zero means write.
// - address bits 18 to 8 are echoed unchanged in the response.
// - bits 7 to 0 carry write data; response returns written or read byte.
// - port addresses equal the addresses used in normal operation.
`timescale 1ns/1ps
`default_nettype none
`include "spp_consts.svh"

module spp_prog_port #(
    parameter int DMEM_DEPTH = 2048,
    parameter int CMEM_DEPTH = 2048
) (
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire logic               modeSelLine,
    input  wire logic               superVoltDet,
    input  wire logic               powerGood,
    input  wire logic               sclk,
    input  wire logic               serialCmdIn,
    output logic                    serialRespOut,
    input  wire logic [7:0]         awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [7:0]         araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output spp_pkg::spp_word_t      rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready
);
    import spp_pkg::*;

    localparam int DAW = $clog2(DMEM_DEPTH);
    localparam int CAW = $clog2(CMEM_DEPTH);

    // folds an 11-bit byte address onto a memory index
    function automatic logic [15:0] memIdx(input spp_addr_t a, input int aw);
        logic [15:0] m;
        m      = 16'((32'h1 << aw) - 1);
        memIdx = {5'h0, a} & m;
    endfunction

    // merge a write under its byte strobes
    function automatic spp_word_t strbMerge(input spp_word_t old,
                                            input spp_word_t nw,
                                            input logic [3:0] st);
        spp_word_t r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        strbMerge = r;
    endfunction

    // pins: {powerGood, superVoltDet, modeSelLine}
    logic [2:0]  pinS1Ff, pinS2Ff, pinS3Ff, pinFFf;
    logic        shS1Ff, shS2Ff, reqS1Ff, reqS2Ff, reqSeenFf;
    logic        progModeFf, svPrevFf;
    spp_op_t     opStateFf;
    logic [15:0] wrCntFf, wrTimeFf, cmdCntFf;
    logic        writeDoneFf, writePendFf, ackTglFf, respOutFf;
    spp_word_t   respWordFf, lastCmdFf;
    logic [17:0] memAddrFf;
    spp_byte_t   dmem [0:DMEM_DEPTH-1];
    spp_byte_t   cmem [0:CMEM_DEPTH-1];
    logic        wrTakeFf, bvalidFf, arTakeFf, rvalidFf;
    logic [1:0]  brespFf, rrespFf;
    spp_word_t   rdataFf;

    wire [31:0] linkCmd;
    wire        linkReq;
    wire        linkBit;

    // link-clock side: shift registers and launch
    spp_link_shift u_link (
        .sclk     (sclk),
        .srst     (srst),
        .modeSel  (modeSelLine),
        .cmdIn    (serialCmdIn),
        .respWord (respWordFf),
        .ackTgl   (ackTglFf),
        .cmdWord  (linkCmd),
        .reqTgl   (linkReq),
        .shiftBit (linkBit)
    );

    // filtered pin levels: a change counts when stages two and three agree
    wire [2:0] nxt_pinF = (pinS2Ff & pinS3Ff) | (pinFFf & (pinS2Ff | pinS3Ff));
    wire       modeSelF = pinFFf[0];
    wire       svF      = pinFFf[1];
    wire       pwrF     = pinFFf[2];

    // command decode; cmdWord is stable while the request toggle is seen
    wire       reqEdge  = reqS2Ff ^ reqSeenFf;
    wire       reqTake  = reqEdge & progModeFf;
    wire       cmdRead  = linkCmd[`SPP_BIT_READ];
    wire       cmdD     = linkCmd[`SPP_BIT_DSPACE];
    wire       cmdC     = linkCmd[`SPP_BIT_CSPACE];
    wire       selD     = cmdD & ~cmdC;
    wire       selC     = cmdC & ~cmdD;
    wire spp_addr_t cmdAddr = linkCmd[`SPP_ADDR_HI:`SPP_ADDR_LO];
    wire spp_byte_t cmdData = linkCmd[`SPP_DATA_HI:`SPP_DATA_LO];
    wire [15:0] cmdDIdx = memIdx(cmdAddr, DAW);
    wire [15:0] cmdCIdx = memIdx(cmdAddr, CAW);
    wire spp_byte_t progRd  = selD ? dmem[cmdDIdx[DAW-1:0]] :
                              selC ? cmem[cmdCIdx[CAW-1:0]] : 8'h00;
    wire spp_byte_t respData = cmdRead ? progRd : cmdData;
    wire       progWrD  = reqTake & ~cmdRead & selD;
    wire       progWrC  = reqTake & ~cmdRead & selC;
    wire       startWr  = reqTake & ~cmdRead;
    wire       wrFinish = (opStateFf == OP_WRITE) && (wrCntFf == 16'd0);

    // core-side view of the same memories at the same addresses
    wire spp_addr_t maAddr = memAddrFf[`SPP_MA_ADDR_HI:0];
    wire       maD      = memAddrFf[`SPP_MA_DSEL] & ~memAddrFf[`SPP_MA_CSEL];
    wire       maC      = memAddrFf[`SPP_MA_CSEL] & ~memAddrFf[`SPP_MA_DSEL];
    wire [15:0] maDIdx  = memIdx(maAddr, DAW);
    wire [15:0] maCIdx  = memIdx(maAddr, CAW);
    wire spp_byte_t maRd = maD ? dmem[maDIdx[DAW-1:0]] :
                           maC ? cmem[maCIdx[CAW-1:0]] : 8'h00;

    // axi write decode
    wire       wrHit    = wrTakeFf;
    wire       wCtrl    = wrHit && (awaddr == `SPP_OFF_CTRL);
    wire       wStat    = wrHit && (awaddr == `SPP_OFF_STATUS);
    wire       wMa      = wrHit && (awaddr == `SPP_OFF_MEMADDR);
    wire       wMd      = wrHit && (awaddr == `SPP_OFF_MEMDATA);
    wire       wRo      = wrHit && ((awaddr == `SPP_OFF_LASTCMD) ||
                                    (awaddr == `SPP_OFF_CMDCNT));
    wire       wMapped  = wCtrl | wStat | wMa | wMd | wRo;
    // the core may not write memory while the programmer owns it
    wire       axiMemWr = wMd & wstrb[0] & ~progModeFf;
    wire       doneClr  = wStat & wstrb[0] & wdata[`SPP_ST_DONE];
    wire [15:0] nxt_wrTime = 16'(strbMerge({16'h0, wrTimeFf}, wdata, wstrb));
    wire [17:0] nxt_memAddr = 18'(strbMerge({14'h0, memAddrFf}, wdata, wstrb));

    wire       nxt_wrTake = ~wrTakeFf & ~bvalidFf & awvalid & wvalid;
    wire       nxt_arTake = ~arTakeFf & ~rvalidFf & arvalid;

    // axi read mux
    wire [31:0] statWord = {28'h0, writePendFf, writeDoneFf,
                            (opStateFf == OP_WRITE), progModeFf};
    wire        rMapped  = (araddr == `SPP_OFF_CTRL)    ||
                           (araddr == `SPP_OFF_STATUS)  ||
                           (araddr == `SPP_OFF_LASTCMD) ||
                           (araddr == `SPP_OFF_MEMADDR) ||
                           (araddr == `SPP_OFF_MEMDATA) ||
                           (araddr == `SPP_OFF_CMDCNT);
    wire [31:0] rdMux =
        (araddr == `SPP_OFF_CTRL)    ? {16'h0, wrTimeFf}  :
        (araddr == `SPP_OFF_STATUS)  ? statWord           :
        (araddr == `SPP_OFF_LASTCMD) ? lastCmdFf          :
        (araddr == `SPP_OFF_MEMADDR) ? {14'h0, memAddrFf} :
        (araddr == `SPP_OFF_MEMDATA) ? {24'h0, maRd}      :
        (araddr == `SPP_OFF_CMDCNT)  ? {16'h0, cmdCntFf}  : 32'h0;

    // response pin: shifted bit while select is high, ready line in write
    wire nxt_respOut = progModeFf &
                       (modeSelF ? shS2Ff : (writePendFf & writeDoneFf));

    assign serialRespOut = respOutFf;
    assign awready       = wrTakeFf;
    assign wready        = wrTakeFf;
    assign bvalid        = bvalidFf;
    assign bresp         = brespFf;
    assign arready       = arTakeFf;
    assign rvalid        = rvalidFf;
    assign rresp         = rrespFf;
    assign rdata         = rdataFf;

    // pin synchronisers; only stage two reads stage one
    always_ff @(posedge mclk) begin
        pinS1Ff <= {powerGood, superVoltDet, modeSelLine};
        pinS2Ff <= pinS1Ff;
        pinS3Ff <= pinS2Ff;
        shS1Ff  <= linkBit;
        shS2Ff  <= shS1Ff;
        reqS1Ff <= linkReq;
        reqS2Ff <= reqS1Ff;
    end

    // filtered pins and programming-mode state
    always_ff @(posedge mclk) begin
        if (srst) begin
            pinFFf     <= 3'b000;
            svPrevFf   <= 1'b0;
            progModeFf <= 1'b0;
        end else begin
            pinFFf   <= nxt_pinF;
            svPrevFf <= svF;
            if (!pwrF) begin
                progModeFf <= 1'b0;
            end else if (svF && !svPrevFf) begin
                progModeFf <= 1'b1;
            end
        end
    end

    // request intake and response build; ack only after answer is stable
    always_ff @(posedge mclk) begin
        if (srst) begin
            reqSeenFf  <= 1'b0;
            ackTglFf   <= 1'b0;
            respWordFf <= 32'h0;
            lastCmdFf  <= 32'h0;
            cmdCntFf   <= 16'h0;
        end else begin
            reqSeenFf <= reqS2Ff;
            if (reqTake) begin
                // unused fields read back as zero
                respWordFf <= {13'h0, cmdAddr, respData};
                lastCmdFf  <= linkCmd;
                cmdCntFf   <= cmdCntFf + 16'd1;
            end
            if (reqEdge) begin
                ackTglFf <= ~ackTglFf;
            end
        end
    end

    // memory write timing and ready state
    always_ff @(posedge mclk) begin
        if (srst) begin
            opStateFf   <= OP_IDLE;
            wrCntFf     <= 16'h0;
            writeDoneFf <= 1'b0;
            writePendFf <= 1'b0;
        end else begin
            case (opStateFf)
                OP_IDLE: begin
                    if (startWr) begin
                        opStateFf <= OP_WRITE;
                        wrCntFf   <= wrTimeFf;
                    end
                end
                OP_WRITE: begin
                    if (wrFinish || !progModeFf) begin
                        opStateFf <= OP_IDLE;
                    end else begin
                        wrCntFf <= wrCntFf - 16'd1;
                    end
                end
                default: begin
                    opStateFf <= OP_IDLE;
                end
            endcase
            // hardware set beats software clear
            if (wrFinish) begin
                writeDoneFf <= 1'b1;
            end else if (startWr || doneClr) begin
                writeDoneFf <= 1'b0;
            end
            if (startWr) begin
                writePendFf <= 1'b1;
            end else if (modeSelF || !progModeFf) begin
                writePendFf <= 1'b0;
            end
        end
    end

    // serial response pin
    always_ff @(posedge mclk) begin
        if (srst) begin
            respOutFf <= 1'b0;
        end else begin
            respOutFf <= nxt_respOut;
        end
    end

    // memory arrays: programmer has priority over the core port
    always_ff @(posedge mclk) begin
        if (progWrD) begin
            dmem[cmdDIdx[DAW-1:0]] <= cmdData;
        end else if (axiMemWr && maD) begin
            dmem[maDIdx[DAW-1:0]] <= wdata[7:0];
        end
        if (progWrC) begin
            cmem[cmdCIdx[CAW-1:0]] <= cmdData;
        end else if (axiMemWr && maC) begin
            cmem[maCIdx[CAW-1:0]] <= wdata[7:0];
        end
    end

    // axi control registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            wrTimeFf  <= `SPP_RST_WRTIME;
            memAddrFf <= `SPP_RST_MEMADDR;
        end else begin
            if (wCtrl) begin
                wrTimeFf <= nxt_wrTime;
            end
            if (wMa) begin
                memAddrFf <= nxt_memAddr;
            end
        end
    end

    // axi write channel: address and data taken together
    always_ff @(posedge mclk) begin
        if (srst) begin
            wrTakeFf <= 1'b0;
            bvalidFf <= 1'b0;
            brespFf  <= `SPP_RESP_OKAY;
        end else begin
            wrTakeFf <= nxt_wrTake;
            if (wrTakeFf) begin
                bvalidFf <= 1'b1;
                brespFf  <= wMapped ? `SPP_RESP_OKAY : `SPP_RESP_SLVERR;
            end else if (bready) begin
                bvalidFf <= 1'b0;
            end
        end
    end

    // axi read channel
    always_ff @(posedge mclk) begin
        if (srst) begin
            arTakeFf <= 1'b0;
            rvalidFf <= 1'b0;
            rrespFf  <= `SPP_RESP_OKAY;
            rdataFf  <= 32'h0;
        end else begin
            arTakeFf <= nxt_arTake;
            if (arTakeFf) begin
                rvalidFf <= 1'b1;
                rdataFf  <= rdMux;
                rrespFf  <= rMapped ? `SPP_RESP_OKAY : `SPP_RESP_SLVERR;
            end else if (rready) begin
                rvalidFf <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

/* pkg/spp_consts.svh */
`ifndef SPP_CONSTS_SVH
`define SPP_CONSTS_SVH

// command and response word layout
`define SPP_CMD_BITS     32
`define SPP_BIT_DSPACE   29
`define SPP_BIT_CSPACE   28
`define SPP_BIT_READ     24
`define SPP_ADDR_HI      18
`define SPP_ADDR_LO      8
`define SPP_DATA_HI      7
`define SPP_DATA_LO      0

// register byte offsets on the AXI4-Lite slave
`define SPP_OFF_CTRL     8'h00
`define SPP_OFF_STATUS   8'h04
`define SPP_OFF_LASTCMD  8'h08
`define SPP_OFF_MEMADDR  8'h0c
`define SPP_OFF_MEMDATA  8'h10
`define SPP_OFF_CMDCNT   8'h14

// status bit positions
`define SPP_ST_MODE      0
`define SPP_ST_BUSY      1
`define SPP_ST_DONE      2
`define SPP_ST_PEND      3

// memory address register fields
`define SPP_MA_ADDR_HI   10
`define SPP_MA_DSEL      16
`define SPP_MA_CSEL      17

// reset values
`define SPP_RST_WRTIME   16'h0040
`define SPP_RST_MEMADDR  18'h00000

// axi responses
`define SPP_RESP_OKAY    2'b00
`define SPP_RESP_SLVERR  2'b10

`endif

/* pkg/spp_pkg.sv */
package spp_pkg;
    // internal memory operation sequencer
    typedef enum logic [0:0] {
        OP_IDLE,
        OP_WRITE
    } spp_op_t;

    typedef logic [31:0] spp_word_t;
    typedef logic [10:0] spp_addr_t;
    typedef logic [7:0]  spp_byte_t;
endpackage

/* verilog/spp_link_shift.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spp_consts.svh"

module spp_link_shift (
    input  wire logic               sclk,
    input  wire logic               srst,
    input  wire logic               modeSel,
    input  wire logic               cmdIn,
    input  wire spp_pkg::spp_word_t respWord,
    input  wire logic               ackTgl,
    output logic [31:0]             cmdWord,
    output logic                    reqTgl,
    output logic                    shiftBit
);
    import spp_pkg::*;

    logic        rstS1Ff, rstS2Ff, ackS1Ff, ackS2Ff;
    logic [5:0]  cntFf;
    logic [31:0] shInFf, cmdFf;
    logic        bitOutFf, reqFf;

    // the answer is read bit by bit once the acknowledge has crossed; it
    // stays put until our next request, so no copy is kept on this side;
    // the link clock only ticks inside frames, so the crossing completes
    // two edges into the word, where the top bits are zero anyway
    wire         full       = (cntFf == 6'd`SPP_CMD_BITS);
    wire         ackOk      = (ackS2Ff == reqFf);
    wire         nxt_bitOut = ackOk & respWord[~cntFf[4:0]];
    wire [5:0]   nxt_cnt    = cntFf + 6'd1;

    assign cmdWord  = cmdFf;
    assign reqTgl   = reqFf;
    assign shiftBit = bitOutFf;

    // level crossings into the link clock
    always_ff @(posedge sclk) begin
        rstS1Ff <= srst;
        rstS2Ff <= rstS1Ff;
        ackS1Ff <= ackTgl;
        ackS2Ff <= ackS1Ff;
    end

    // shift engine: sample on rising edge, present next bit after it
    always_ff @(posedge sclk) begin
        if (rstS2Ff) begin
            cntFf    <= 6'd0;
            shInFf   <= 32'h0;
            bitOutFf <= 1'b0;
            reqFf    <= 1'b0;
            cmdFf    <= 32'h0;
        end else if (modeSel) begin
            if (!full) begin
                shInFf   <= {shInFf[30:0], cmdIn};
                bitOutFf <= nxt_bitOut;
                cntFf    <= nxt_cnt;
            end
        end else begin
            // first low-phase edge launches; a short word is dropped
            if (full) begin
                cmdFf <= shInFf;
                reqFf <= ~reqFf;
            end
            cntFf <= 6'd0;
        end
    end
endmodule

`default_nettype wire

/* testbench/spp_prog_port_props.sv */
`timescale 1ns/1ps
`default_nettype none

module spp_prog_port_props (
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire logic               modeSelLine,
    input  wire logic               serialRespOut,
    input  wire logic               awvalid,
    input  wire logic               awready,
    input  wire logic               wvalid,
    input  wire logic               wready,
    input  wire logic [1:0]         bresp,
    input  wire logic               bvalid,
    input  wire logic               bready,
    input  wire logic               arvalid,
    input  wire logic               arready,
    input  wire spp_pkg::spp_word_t rdata,
    input  wire logic [1:0]         rresp,
    input  wire logic               rvalid,
    input  wire logic               rready
);
    import spp_pkg::*;

    // everything here lives in the core clock domain
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // address and data share one flop, so they are taken on the same beat
    property p_aw_w_pair;
        awready |-> wready && awvalid && wvalid;
    endproperty
    a_aw_w_pair: assert property (p_aw_w_pair)
        else $error("write address and data taken apart");

    property p_b_follows;
        awready |=> bvalid && !awready;
    endproperty
    a_b_follows: assert property (p_b_follows)
        else $error("write response late or accept not a pulse");

    property p_b_holds;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_holds: assert property (p_b_holds)
        else $error("write response dropped before bready");

    property p_b_code;
        bvalid |-> bresp == 2'b00 || bresp == 2'b10;
    endproperty
    a_b_code: assert property (p_b_code)
        else $error("write response code out of range");

    property p_r_follows;
        arready |-> arvalid ##1 (rvalid && !arready);
    endproperty
    a_r_follows: assert property (p_r_follows)
        else $error("read data late or accept not a pulse");

    property p_r_holds;
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_r_holds: assert property (p_r_holds)
        else $error("read data changed before rready");

    property p_r_done;
        rvalid && rready |=> !rvalid;
    endproperty
    a_r_done: assert property (p_r_done)
        else $error("read data not retired after rready");

    // the ready pin must be low before the second launch pulse arrives
    property p_ready_low;
        $fell(modeSelLine) |-> ##[1:8] !serialRespOut;
    endproperty
    a_ready_low: assert property (p_ready_low)
        else $error("ready pin not low after select fell");

    // once ready shows with select low, it stands for the next two cycles
    property p_ready_holds;
        $rose(serialRespOut) && !modeSelLine && !$past(modeSelLine, 8)
            |=> serialRespOut [*2];
    endproperty
    a_ready_holds: assert property (p_ready_holds)
        else $error("ready pin fell during launch phase");
endmodule

bind spp_prog_port spp_prog_port_props i_spp_prog_port_props (
    .mclk, .srst, .modeSelLine, .serialRespOut, .awvalid, .awready,
    .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready
);

`default_nettype wire

/* testbench/spp_programmer_model.sv */
`timescale 1ns/1ps
`default_nettype none

module spp_programmer_model (
    input  wire logic mclk,
    input  wire logic serialRespOut,
    output logic      modeSelLine,
    output logic      superVoltDet,
    output logic      powerGood,
    output logic      sclk,
    output logic      serialCmdIn
);
    import spp_pkg::*;

    // link clock stands still outside frames
    initial begin
        modeSelLine  = 1'b0;
        superVoltDet = 1'b0;
        powerGood    = 1'b1;
        sclk         = 1'b0;
        serialCmdIn  = 1'b0;
    end

    // link clock pulses at a 15 ns period
    task automatic pulses(input int n);
        repeat (n) begin
            sclk = 1'b1;
            #7.5;
            sclk = 1'b0;
            #7.5;
        end
    endtask

    // supervoltage entry; the select line then sits at its normal level
    task automatic enter();
        superVoltDet <= 1'b1;
        repeat (8) @(posedge mclk);
        superVoltDet <= 1'b0;
    endtask

    // supply drop; a fresh entry is needed after this
    task automatic power_cycle();
        powerGood <= 1'b0;
        repeat (10) @(posedge mclk);
        powerGood <= 1'b1;
        repeat (10) @(posedge mclk);
    endtask

    // one frame; sampling waits long after each pulse, as a slow programmer
    task automatic xfer(input spp_word_t cmd, output spp_word_t rsp,
                        output logic lo, output logic rdy);
        modeSelLine <= 1'b1;
        repeat (8) @(posedge mclk);
        for (int k = 31; k >= 0; k--) begin
            serialCmdIn = cmd[k];
            #3;
            pulses(1);
            #36;
            rsp[k] = serialRespOut;
            #2;
        end
        #3;
        modeSelLine <= 1'b0;
        serialCmdIn = ~cmd[0]; // released line must not look held
        #50;
        pulses(2);
        lo  = serialRespOut;
        rdy = 1'b1;
        if (!cmd[24]) begin
            repeat (400) begin
                @(posedge mclk);
                if (serialRespOut === 1'b1) break;
            end
            rdy = serialRespOut;
        end
    endtask
endmodule

`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spp_consts.svh"

module testbench;
    import spp_pkg::*;

    logic        mclk, srst, sclk, modeSelLine, superVoltDet;
    logic        powerGood, serialCmdIn, serialRespOut, lo, rdy;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    spp_word_t   wdata, rdata, d, rsp;
    int          n_fail, n_tests;
    // data space, code space, read bit; responses echo the previous word
    spp_word_t   cmds [8] = '{32'h2000_05a5, 32'h1007_ff3c, 32'h2107_ff00,
                              32'h1107_ff00, 32'h3100_0500, 32'h0100_0500,
                              32'h2100_0500, 32'h1100_0000};
    logic [18:0] exps [8] = '{19'h0, 19'h005a5, 19'h7ff3c, 19'h7ff11,
                              19'h7ff3c, 19'h00500, 19'h00500, 19'h005a5};

    spp_prog_port i_spp_prog_port (
        .mclk, .srst, .modeSelLine, .superVoltDet, .powerGood, .sclk,
        .serialCmdIn, .serialRespOut, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
    );

    spp_programmer_model i_spp_programmer_model (
        .mclk, .serialRespOut, .modeSelLine, .superVoltDet, .powerGood,
        .sclk, .serialCmdIn
    );

    // core clock, 8 ns
    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    // register write; bready stays up until the response is seen
    task automatic wr(input logic [7:0] a, input spp_word_t v);
        @(posedge mclk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do @(posedge mclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge mclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        r = bresp;
    endtask

    // register read
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask

    task automatic chk(input string n, input spp_word_t e, input spp_word_t g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // main sequence; the link clock ticks across reset and its release,
    // since the link side sees reset through two flops of its own clock
    initial begin
        {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata, wstrb} = {8'h0, 8'h0, 32'h0, 4'hf};
        n_fail  = 0;
        n_tests = 0;
        fork
            begin #3; i_spp_programmer_model.pulses(6); end
        join_none
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        rd(`SPP_OFF_CTRL);
        chk("ctrl", 32'h40, d);
        rd(`SPP_OFF_STATUS);
        chk("status", 32'h0, d);
        rd(8'h18);
        chk("rd unmapped", 32'h2, {30'h0, r});
        wr(8'h18, 32'h5);
        chk("wr unmapped", 32'h2, {30'h0, r});
        wr(`SPP_OFF_CTRL, 32'h8);
        wr(`SPP_OFF_MEMADDR, 32'h1_07ff);
        wr(`SPP_OFF_MEMDATA, 32'h11);
        i_spp_programmer_model.enter();
        for (int i = 0; i < 8; i++) begin
            i_spp_programmer_model.xfer(cmds[i], rsp, lo, rdy);
            if (i > 0) chk("resp", {13'h0, exps[i]}, rsp & 32'h7ffff);
            if (!cmds[i][24]) begin
                chk("ready low", 32'h0, {31'h0, lo});
                chk("ready high", 32'h1, {31'h0, rdy});
            end
        end
        rd(`SPP_OFF_CMDCNT);
        chk("cmdcnt", 32'h8, d);
        rd(`SPP_OFF_LASTCMD);
        chk("lastcmd", cmds[7], d);
        rd(`SPP_OFF_STATUS);
        chk("status done", 32'h5, d & 32'h5);
        wr(`SPP_OFF_STATUS, 32'h4);
        rd(`SPP_OFF_STATUS);
        chk("done cleared", 32'h0, d & 32'h4);
        wr(`SPP_OFF_MEMADDR, 32'h2_07ff);
        wr(`SPP_OFF_MEMDATA, 32'h77);
        rd(`SPP_OFF_MEMDATA);
        chk("code byte", 32'h3c, d);
        i_spp_programmer_model.power_cycle();
        rd(`SPP_OFF_STATUS);
        chk("mode off", 32'h0, d & 32'h1);
        i_spp_programmer_model.xfer(cmds[6], rsp, lo, rdy);
        rd(`SPP_OFF_CMDCNT);
        chk("cmdcnt off", 32'h8, d);
        end_of_test();
    end

    // the whole run needs about 20 us; a hang is cut off well beyond that
    initial begin
        #100000;
        n_fail++;
        end_of_test();
    end
endmodule

`default_nettype wire
